/* File: hdl/dadc_path_ctrl.sv */
// Purpose: Routing and mode control for the dual decimation path.
// Assumes: Samples come from the converter cores on mclk; register port on mclk.
// Notes:   Filters themselves live downstream; this block steers and configures them.
//          Every output leaves a flop, so a new setting shows one edge after its write lands.
//          One tuning word serves both channels; separate words would cost four more registers.
`timescale 1ns/1ns
`default_nettype none
module dadc_path_ctrl
    import dadc_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic [dadc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [dadc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output var  logic [dadc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [dadc_pkg::SAMP_W-1:0]  samp_a,
    input  wire logic [dadc_pkg::SAMP_W-1:0]  samp_b,
    output var  logic [dadc_pkg::SAMP_W-1:0]  filt_in_a,
    output var  logic [dadc_pkg::SAMP_W-1:0]  filt_in_b,
    output var  logic                         feature_path_include,
    output var  logic                         decimator_enable,
    output var  logic [2:0]                   decim_factor,
    output var  logic                         decim_active,
    output var  logic                         real_mode,
    output var  logic                         phase_invert,
    output var  logic [dadc_pkg::NCO_W-1:0]   tuning_word,
    output var  logic [dadc_pkg::PAT_W-1:0]   frame_clock_pattern
);
    import dadc_pkg::*;

    // Configuration state.
    logic [7:0]        route_r;        // Routing register.
    logic [7:0]        route_nxt;      // Next routing value.
    logic [7:0]        decim_r;        // Mode register.
    logic [7:0]        decim_nxt;      // Next mode value.
    logic [PAT_W-1:0]  pat_r;          // Programmed frame pattern.
    logic [PAT_W-1:0]  pat_nxt;        // Next pattern.
    logic [NCO_W-1:0]  nco_r;          // Programmed tuning word.
    logic [NCO_W-1:0]  nco_nxt;        // Next tuning word.
    logic [7:0]        rdata_nxt;      // Read data next value.

    // Output-stage state.
    logic [SAMP_W-1:0] fa_nxt;         // Next filter A input.
    logic [SAMP_W-1:0] fb_nxt;         // Next filter B input.
    logic [SAMP_W:0]   avg_sum;        // Sign-extended sum of both channels.
    logic [SAMP_W-1:0] avg_val;        // Average of both channels.
    logic [1:0]        sel_code;       // Effective select code.
    logic [2:0]        dec_code;       // Raw decimation field.
    logic [PAT_W-1:0]  pat_eff;        // Effective frame pattern.
    logic [NCO_W-1:0]  nco_eff;        // Effective tuning word.
    logic [1:0]        nco_idx;        // Byte lane of the tuning word under access.

    // Byte lane of the tuning word; only meaningful inside the tuning address range.
    assign nco_idx = 2'(reg_addr - ADDR_NCO0);

    // Register writes; reserved bits are masked so they always read zero.
    // Masking on the way in means a careless host cannot leave a latent 1 in a spare bit.
    always_comb
    begin
        route_nxt = route_r;
        decim_nxt = decim_r;
        pat_nxt   = pat_r;
        nco_nxt   = nco_r;
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_ROUTE: route_nxt = reg_wdata & ROUTE_MASK;
                ADDR_DECIM: decim_nxt = reg_wdata & DECIM_MASK;
                ADDR_PAT0:  pat_nxt[7:0] = reg_wdata;
                ADDR_PAT1:  pat_nxt[15:8] = reg_wdata;
                // Upper nibble of pattern byte 2 has no storage and is dropped.
                ADDR_PAT2:  pat_nxt[19:16] = reg_wdata[3:0];
                default:
                begin
                    // Tuning word bytes sit at four consecutive addresses.
                    if (reg_addr >= ADDR_NCO0 && reg_addr <= ADDR_NCO3)
                    begin
                        nco_nxt[{nco_idx, 3'h0} +: 8] = reg_wdata;
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero. Effective tuning word is shown.
    // Data are zero outside the cycle after a read, so a stale value never looks like an answer.
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_ROUTE: rdata_nxt = route_r;
                ADDR_DECIM: rdata_nxt = decim_r;
                ADDR_PAT0:  rdata_nxt = pat_eff[7:0];
                ADDR_PAT1:  rdata_nxt = pat_eff[15:8];
                ADDR_PAT2:  rdata_nxt = {4'h0, pat_eff[19:16]};
                default:
                begin
                    if (reg_addr >= ADDR_NCO0 && reg_addr <= ADDR_NCO3)
                    begin
                        // Tuning bytes report the effective word, so software sees the forced zero.
                        rdata_nxt = nco_eff[{nco_idx, 3'h0} +: 8];
                    end
                end
            endcase
        end
    end

    // Register file flops.
    // The read data flop sits here too, which gives the fixed one-cycle read latency.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            route_r   <= RESET_VAL;
            decim_r   <= RESET_VAL;
            pat_r     <= PAT_DEFAULT;
            nco_r     <= NCO_ZERO;
            reg_rdata <= 8'h00;
        end
        else
        begin
            route_r   <= route_nxt;
            decim_r   <= decim_nxt;
            pat_r     <= pat_nxt;
            nco_r     <= nco_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // Routing and mode decode.
    // Everything here reads only flopped configuration and the current samples.
    // The output flops below add the single cycle of latency on the sample path.
    always_comb
    begin
        dec_code = decim_r[BIT_DEC_HI:BIT_DEC_LO];
        // Selector idles at straight-through routing while disabled.
        sel_code = decim_r[BIT_SEL_EN] ? route_r[BIT_SEL_HI:BIT_SEL_LO] : 2'h0;
        // Arithmetic shift keeps the average correct for signed samples, rounding odd sums down.
        // One guard bit keeps the sum from wrapping when both channels sit near full scale.
        avg_sum  = {samp_a[SAMP_W-1], samp_a} + {samp_b[SAMP_W-1], samp_b};
        avg_val  = avg_sum[SAMP_W:1];
        case (dadc_sel_t'(sel_code))
            DADC_SEL_SPLIT:
            begin
                fa_nxt = samp_a;
                fb_nxt = samp_b;
            end
            DADC_SEL_A:
            begin
                fa_nxt = samp_a;
                fb_nxt = samp_a;
            end
            DADC_SEL_B:
            begin
                fa_nxt = samp_b;
                fb_nxt = samp_b;
            end
            DADC_SEL_AVG:
            begin
                // Without the average enable the averager is idle; pass A as a safe default.
                fa_nxt = route_r[BIT_AVG] ? avg_val : samp_a;
                fb_nxt = route_r[BIT_AVG] ? avg_val : samp_a;
            end
            default:
            begin
                fa_nxt = samp_a;
                fb_nxt = samp_b;
            end
        endcase
        // Bypass or unused codes leave the programmed pattern out of play.
        pat_eff = (dec_code == DEC_BYPASS || dec_code > DEC_MAX) ? PAT_AUTO : pat_r;
        nco_eff = decim_r[BIT_REAL] ? NCO_ZERO : nco_r;
    end

    // Outputs all leave from flops.
    // Registering every output keeps decode glitches away from the downstream filters.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            filt_in_a            <= '0;
            filt_in_b            <= '0;
            feature_path_include <= 1'b0;
            decimator_enable     <= 1'b0;
            decim_factor         <= DEC_BYPASS;
            decim_active         <= 1'b0;
            real_mode            <= 1'b0;
            phase_invert         <= 1'b0;
            tuning_word          <= NCO_ZERO;
            frame_clock_pattern  <= PAT_AUTO;
        end
        else
        begin
            filt_in_a            <= fa_nxt;
            filt_in_b            <= fb_nxt;
            feature_path_include <= route_r[BIT_FEAT];
            decimator_enable     <= route_r[BIT_DEC_EN];
            // Unused codes fall back to bypass rather than an undefined factor.
            decim_factor         <= (dec_code > DEC_MAX) ? DEC_BYPASS : dec_code;
            // Decimation only runs with the feature path in and the filters switched on.
            decim_active         <= route_r[BIT_FEAT] && route_r[BIT_DEC_EN]
                                    && dec_code != DEC_BYPASS && dec_code <= DEC_MAX;
            real_mode            <= decim_r[BIT_REAL];
            phase_invert         <= decim_r[BIT_PHASE_INV];
            tuning_word          <= nco_eff;
            frame_clock_pattern  <= pat_eff;
        end
    end

    // Checks.
    // Each one looks one edge past the decode, where the output flops have taken the new value.

    // Routing checks.
    a_avg_route: assert property (@(posedge mclk) disable iff (rst)
        (decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] == DADC_SEL_AVG && route_r[BIT_AVG]
         && $stable(route_r) && $stable(decim_r))
        |=> filt_in_a == $past(avg_val) && filt_in_b == filt_in_a)
        else $error("Averaged sample not routed.");
    a_sel_disabled: assert property (@(posedge mclk) disable iff (rst)
        !decim_r[BIT_SEL_EN] |=> filt_in_a == $past(samp_a) && filt_in_b == $past(samp_b))
        else $error("Selector acted while disabled.");
    a_sel_split: assert property (@(posedge mclk) disable iff (rst)
        (decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] == DADC_SEL_SPLIT)
        |=> filt_in_a == $past(samp_a) && filt_in_b == $past(samp_b))
        else $error("Straight routing broken.");
    a_sel_b_both: assert property (@(posedge mclk) disable iff (rst)
        (decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] == DADC_SEL_B)
        |=> filt_in_a == $past(samp_b) && filt_in_b == $past(samp_b))
        else $error("Channel B not sent to both filters.");
    a_sel_a_both: assert property (@(posedge mclk) disable iff (rst)
        (decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] == DADC_SEL_A)
        |=> filt_in_a == $past(samp_a) && filt_in_b == $past(samp_a))
        else $error("Channel A not sent to both filters.");

    // Mode checks.
    a_include_bit: assert property (@(posedge mclk) disable iff (rst)
        !route_r[BIT_FEAT] |=> !feature_path_include && !decim_active)
        else $error("Feature path active while bypassed.");
    a_dec_enable: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> decimator_enable == $past(route_r[BIT_DEC_EN]))
        else $error("Decimator enable does not follow its bit.");
    a_dec_off: assert property (@(posedge mclk) disable iff (rst)
        !route_r[BIT_DEC_EN] |=> !decim_active)
        else $error("Decimation active while disabled.");
    a_dec_code: assert property (@(posedge mclk) disable iff (rst)
        dec_code > DEC_MAX |=> decim_factor == DEC_BYPASS)
        else $error("Unused decimation code passed on.");
    a_dec_pass: assert property (@(posedge mclk) disable iff (rst)
        (dec_code <= DEC_MAX) |=> decim_factor == $past(dec_code))
        else $error("Valid decimation code not passed on.");
    a_real_follow: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> real_mode == $past(decim_r[BIT_REAL]))
        else $error("Real mode does not follow its bit.");
    a_real_zero: assert property (@(posedge mclk) disable iff (rst)
        decim_r[BIT_REAL] |=> tuning_word == NCO_ZERO && real_mode)
        else $error("Tuning word not zero in real mode.");
    a_tune_pass: assert property (@(posedge mclk) disable iff (rst)
        !decim_r[BIT_REAL] |=> tuning_word == $past(nco_r))
        else $error("Programmed tuning word not passed on.");
    a_phase_inv: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> phase_invert == $past(decim_r[BIT_PHASE_INV]))
        else $error("Phase invert does not follow its bit.");

    // Pattern and register checks.
    a_pat_auto: assert property (@(posedge mclk) disable iff (rst)
        dec_code == DEC_BYPASS |=> frame_clock_pattern == PAT_AUTO)
        else $error("Pattern not auto-set in bypass.");
    a_pat_prog: assert property (@(posedge mclk) disable iff (rst)
        (dec_code != DEC_BYPASS && dec_code <= DEC_MAX) |=> frame_clock_pattern == $past(pat_r))
        else $error("Programmed pattern not used while decimating.");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
        reg_rd && reg_addr == ADDR_ROUTE |=> reg_rdata[7:6] == 2'h0 && reg_rdata[0] == 1'b0)
        else $error("Reserved bits read nonzero.");

    // Main scenarios worth seeing at least once.
    c_avg_mode: cover property (@(posedge mclk) disable iff (rst)
        decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] == DADC_SEL_AVG && route_r[BIT_AVG]);
    c_dec32: cover property (@(posedge mclk) disable iff (rst) decim_active && decim_factor == DEC_MAX);
    c_real: cover property (@(posedge mclk) disable iff (rst) real_mode && decim_active);
    c_wr_rd: cover property (@(posedge mclk) disable iff (rst) reg_wr ##1 reg_rd);
    c_sel_off: cover property (@(posedge mclk) disable iff (rst)
        !decim_r[BIT_SEL_EN] && route_r[BIT_SEL_HI:BIT_SEL_LO] != DADC_SEL_SPLIT);
endmodule
`default_nettype wire

/* File: hdl/dadc_pkg.sv */
// Purpose: Shared constants for the decimation path control block.
// Assumes: 8-bit register port, 14-bit converter samples.
// Notes:   Offsets are byte addresses on the plain register port.
package dadc_pkg;
    localparam int          SAMP_W          = 14;            // Converter sample width.
    localparam int          ADDR_W          = 8;             // Register address width.
    localparam int          DATA_W          = 8;             // Register data width.
    localparam int          NCO_W           = 32;            // Tuning word width.
    localparam int          PAT_W           = 20;            // Frame clock pattern width.
    localparam logic [7:0]  ADDR_PAT0       = 8'h20;         // Pattern bits 7..0.
    localparam logic [7:0]  ADDR_PAT1       = 8'h21;         // Pattern bits 15..8.
    localparam logic [7:0]  ADDR_PAT2       = 8'h22;         // Pattern bits 19..16.
    localparam logic [7:0]  ADDR_ROUTE      = 8'h24;         // Datapath routing register.
    localparam logic [7:0]  ADDR_DECIM      = 8'h25;         // Decimation mode register.
    localparam logic [7:0]  ADDR_NCO0       = 8'h2A;         // Tuning word bits 7..0.
    localparam logic [7:0]  ADDR_NCO3       = 8'h2D;         // Tuning word bits 31..24.
    localparam logic [7:0]  RESET_VAL       = 8'h00;         // Reset value of both config registers.
    localparam logic [7:0]  ROUTE_MASK      = 8'h3E;         // Implemented bits of the routing register.
    localparam logic [7:0]  DECIM_MASK      = 8'hF9;         // Implemented bits of the mode register.
    localparam logic [7:0]  PAT2_MASK       = 8'h0F;         // Implemented bits of pattern byte 2.
    localparam int          BIT_AVG         = 5;             // Channel average enable.
    localparam int          BIT_SEL_HI      = 4;             // Input select high bit.
    localparam int          BIT_SEL_LO      = 3;             // Input select low bit.
    localparam int          BIT_FEAT        = 2;             // Feature path include.
    localparam int          BIT_DEC_EN      = 1;             // Decimator enable.
    localparam int          BIT_SEL_EN      = 7;             // Input select enable.
    localparam int          BIT_DEC_HI      = 6;             // Decimation field high bit.
    localparam int          BIT_DEC_LO      = 4;             // Decimation field low bit.
    localparam int          BIT_REAL        = 3;             // Real output select.
    localparam int          BIT_PHASE_INV   = 0;             // Oscillator phase invert.
    localparam logic [2:0]  DEC_BYPASS      = 3'h0;          // No decimation.
    localparam logic [2:0]  DEC_MAX         = 3'h5;          // Decimation by 32.
    localparam logic [19:0] PAT_DEFAULT     = 20'h00000;     // Pattern reset value.
    localparam logic [19:0] PAT_AUTO        = 20'hFC000;     // Pattern used while decimation is bypassed.
    localparam logic [31:0] NCO_ZERO        = 32'h00000000;  // Tuning word forced in real mode.
    typedef enum logic [1:0] {
        DADC_SEL_SPLIT,
        DADC_SEL_A,
        DADC_SEL_B,
        DADC_SEL_AVG
    } dadc_sel_t;                                            // Filter input routing choices.
endpackage

/* File: verification/dadc_capture_model.sv */
// Purpose: Behavioural model of the capture logic that takes the filter inputs.
// Assumes: Capture runs on mclk and registers each sample once.
// Notes:   Adds one cycle of latency, like a real capture flop stage.
`timescale 1ns/1ns
`default_nettype none
module dadc_capture_model
    import dadc_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [dadc_pkg::SAMP_W-1:0] filt_in_a,
    input  wire logic [dadc_pkg::SAMP_W-1:0] filt_in_b,
    output var  logic [dadc_pkg::SAMP_W-1:0] cap_a_r,
    output var  logic [dadc_pkg::SAMP_W-1:0] cap_b_r
);
    import dadc_pkg::*;

    logic [SAMP_W-1:0] cap_a_nxt;  // Next captured channel A word.
    logic [SAMP_W-1:0] cap_b_nxt;  // Next captured channel B word.

    // Take whatever the filters are fed; no gating, so a wrong route shows.
    always_comb
    begin
        cap_a_nxt = filt_in_a;
        cap_b_nxt = filt_in_b;
    end

    // Register the capture; reset clears it so stale words never look valid.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cap_a_r <= '0;
            cap_b_r <= '0;
        end
        else
        begin
            cap_a_r <= cap_a_nxt;
            cap_b_r <= cap_b_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the decimation path control block.
// Assumes: Plain register port with one cycle read latency, single clock.
// Notes:   Samples are held steady, so routing checks do not hinge on latency.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    import dadc_pkg::*;
    logic              mclk = 1'b0;      // Sample clock, 4 ns period.
    logic              rst = 1'b1;       // Asynchronous reset, held at start.
    logic [ADDR_W-1:0] reg_addr = 8'h00; // Register address.
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [SAMP_W-1:0] samp_a = 14'h0000;
    logic [SAMP_W-1:0] samp_b = 14'h0000;
    logic [SAMP_W-1:0] filt_in_a, filt_in_b, cap_a, cap_b;
    logic              feature_path_include, decimator_enable, decim_active, real_mode, phase_invert;
    logic [2:0]        decim_factor;
    logic [NCO_W-1:0]  tuning_word;
    logic [PAT_W-1:0]  frame_clock_pattern;
    int                num_errors = 0;   // Mismatches seen.
    int                checks = 0;       // Comparisons made.

    always #2 mclk = ~mclk;

    dadc_path_ctrl uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_a(samp_a), .samp_b(samp_b), .filt_in_a(filt_in_a),
        .filt_in_b(filt_in_b), .feature_path_include(feature_path_include), .decimator_enable(decimator_enable),
        .decim_factor(decim_factor), .decim_active(decim_active), .real_mode(real_mode),
        .phase_invert(phase_invert), .tuning_word(tuning_word), .frame_clock_pattern(frame_clock_pattern));
    dadc_capture_model cap (.mclk(mclk), .rst(rst), .filt_in_a(filt_in_a), .filt_in_b(filt_in_b),
        .cap_a_r(cap_a), .cap_b_r(cap_b));

    // One write cycle; the leading edge keeps a gap so no strobe is assigned twice at once.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // One read cycle; data are looked at only in the cycle after the strobe.
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Let configuration and the capture stage settle.
    task settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // Reset values, reserved bits and an unmapped address.
    task t_regs;
        logic [7:0] d;
        settle();
        `CHK(frame_clock_pattern, PAT_AUTO)
        rd(ADDR_ROUTE, d);
        `CHK(d, RESET_VAL)
        rd(ADDR_DECIM, d);
        `CHK(d, RESET_VAL)
        wr(ADDR_ROUTE, 8'hFF);
        wr(ADDR_DECIM, 8'hFF);
        wr(8'h30, 8'h5A);
        rd(ADDR_ROUTE, d);
        `CHK(d, 8'h3E)
        rd(ADDR_DECIM, d);
        `CHK(d, 8'hF9)
        rd(8'h30, d);
        `CHK(d, 8'h00)
    endtask

    // Every selector code, then the channel-A code with the selector switched off.
    task t_route;
        logic [13:0] ea;
        logic [13:0] eb;
        @(posedge mclk);
        samp_a <= 14'h0065;
        samp_b <= 14'h3FCE;
        wr(ADDR_DECIM, 8'h80);
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_ROUTE, 8'h26 | 8'(s << 3));
            settle();
            ea = (s == 2) ? 14'h3FCE : (s == 3) ? 14'h0019 : 14'h0065;
            eb = (s == 1) ? 14'h0065 : (s == 3) ? 14'h0019 : 14'h3FCE;
            `CHK(cap_a, ea)
            `CHK(cap_b, eb)
        end
        wr(ADDR_DECIM, 8'h00);
        wr(ADDR_ROUTE, 8'h0E);
        settle();
        `CHK(cap_b, 14'h3FCE)
    endtask

    // All decimation codes in real mode, so the one-lane 14-bit pattern applies; include and enable bits.
    task t_decim;
        wr(ADDR_PAT0, 8'h00);
        wr(ADDR_PAT1, 8'hE0);
        wr(ADDR_PAT2, 8'h0F);
        wr(ADDR_ROUTE, 8'h06);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_DECIM, 8'(c << 4) | 8'h08);
            settle();
            `CHK(decim_factor, (c <= 5) ? 3'(c) : 3'h0)
            `CHK(decim_active, (c >= 1 && c <= 5))
            `CHK(frame_clock_pattern, (c >= 1 && c <= 5) ? 20'hFE000 : PAT_AUTO)
        end
        wr(ADDR_DECIM, 8'h18);
        wr(ADDR_ROUTE, 8'h02);
        settle();
        `CHK({feature_path_include, decimator_enable, decim_active}, 3'b010)
        wr(ADDR_ROUTE, 8'h04);
        settle();
        `CHK({feature_path_include, decimator_enable, decim_active}, 3'b100)
    endtask

    // Tuning word bytes, phase invert, and the forced zero in real mode.
    task t_mode;
        logic [7:0] d;
        wr(ADDR_NCO0, 8'h78);
        wr(8'h2B, 8'h56);
        wr(8'h2C, 8'h34);
        wr(ADDR_NCO3, 8'h12);
        wr(ADDR_PAT0, 8'hFF);
        wr(ADDR_PAT1, 8'hFF);
        wr(ADDR_PAT2, 8'h0F);
        wr(ADDR_ROUTE, 8'h06);
        wr(ADDR_DECIM, 8'h11);
        settle();
        `CHK(tuning_word, 32'h12345678)
        `CHK({real_mode, phase_invert}, 2'b01)
        `CHK(frame_clock_pattern, 20'hFFFFF)
        rd(ADDR_PAT2, d);
        `CHK(d, 8'h0F)
        wr(ADDR_DECIM, 8'h18);
        wr(ADDR_PAT1, 8'hE0);
        wr(ADDR_PAT0, 8'h00);
        settle();
        `CHK(frame_clock_pattern, 20'hFE000)
        `CHK(tuning_word, NCO_ZERO)
        `CHK({real_mode, phase_invert}, 2'b10)
        rd(ADDR_NCO3, d);
        `CHK(d, 8'h00)
    endtask

    // Print the verdict and stop; shared by the main sequence and the watchdog.
    task wrap_up;
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: reset for four cycles, then each scenario in turn.
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_route();
        t_decim();
        t_mode();
        wrap_up();
    end

    // The scenarios need well under a thousand cycles; five thousand means a hang.
    initial
    begin
        #20000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
